/* File: src/dept_pkg.sv */
// Package: constants for the dual encoder position trigger block
// Function
// - A programmable lower window bound blocks triggers below it.
// - A programmable upper window bound blocks triggers above it.
// - Each encoder has its own interpolation depth of 1, 2 or 4.
// - With reference policy none, reference marks leave the counter alone.
// - With policy once, only the first mark after arming loads the preload.
// - With policy every, each reference mark loads the preload.
// - Each encoder has a 32-bit preload used on reference or soft load.
// - Writing a preload value re-arms that encoder's first-mark detection.
// - Soft load acts only with policy none and is otherwise ignored.
// - Re-arm command acts only with policy once and is otherwise ignored.
// - Each counter wraps to zero after passing its programmable maximum.
// - One trigger per step interval; zero step triggers continuously.
// - Encoder triggering runs only when the origin selects encoder a or b.
package dept_pkg;
  localparam logic [31:0] APB_PRELOAD_A  = 32'h0000_0000;
  localparam logic [31:0] APB_PRELOAD_B  = 32'h0000_0004;
  localparam logic [31:0] APB_WRAP_A     = 32'h0000_0008;
  localparam logic [31:0] APB_WRAP_B     = 32'h0000_000C;
  localparam logic [31:0] APB_WIN_LOW    = 32'h0000_0010;
  localparam logic [31:0] APB_WIN_HIGH   = 32'h0000_0014;
  localparam logic [31:0] APB_STEP       = 32'h0000_0018;
  localparam logic [31:0] APB_CONFIG     = 32'h0000_001C;
  localparam logic [31:0] APB_COMMAND    = 32'h0000_0020;
  localparam logic [31:0] APB_COUNT_A    = 32'h0000_0024;
  localparam logic [31:0] APB_COUNT_B    = 32'h0000_0028;
  localparam logic [31:0] APB_STATUS     = 32'h0000_002C;
  // Config layout
  localparam int CFG_DEPTH_A_LSB  = 0;
  localparam int CFG_DEPTH_B_LSB  = 2;
  localparam int CFG_POLICY_A_LSB = 4;
  localparam int CFG_POLICY_B_LSB = 6;
  localparam int CFG_ORIGIN_LSB   = 8;
  localparam int CFG_WIDTH        = 11;
  // Command layout (write-only pulses)
  localparam int CMD_LOAD_A  = 0;
  localparam int CMD_LOAD_B  = 1;
  localparam int CMD_REARM_A = 2;
  localparam int CMD_REARM_B = 3;
  // Reset values
  localparam logic [31:0] RST_WRAP       = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_WIN_HIGH   = 32'hFFFF_FFFF;
  localparam logic [CFG_WIDTH-1:0] RST_CFG = 11'h000;
  typedef enum logic [1:0] {
    DEPTH_X1 = 2'h0,
    DEPTH_X2 = 2'h1,
    DEPTH_X4 = 2'h2
  } dept_depth_t;
  typedef enum logic [1:0] {
    REF_NONE  = 2'h0,
    REF_ONCE  = 2'h1,
    REF_EVERY = 2'h2
  } dept_policy_t;
  typedef enum logic [2:0] {
    ORG_NONE     = 3'h0,
    ORG_SYNCTRIG = 3'h1,
    ORG_TRIGIN   = 3'h2,
    ORG_SOFTWARE = 3'h3,
    ORG_ENC_A    = 3'h4,
    ORG_ENC_B    = 3'h5
  } dept_origin_t;
endpackage

/* File: src/dept_top.sv */
// Dual encoder counters with window and step trigger, APB slave
`timescale 1ns/1ps
module dept_top #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [31:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Encoder pins
  input  wire logic        ENC_A_PHASE_A,
  input  wire logic        ENC_A_PHASE_B,
  input  wire logic        ENC_A_REF,
  input  wire logic        ENC_B_PHASE_A,
  input  wire logic        ENC_B_PHASE_B,
  input  wire logic        ENC_B_REF,
  // Trigger out
  output logic             MEAS_TRIG
);
  if (CNT_W != 32)
  begin
    $error("dept_top: CNT_W must be 32");
  end

  // Synchronisers: stage 1 feeds only stage 2
  logic [5:0] pin_s1_r;
  logic [5:0] pin_s2_r;
  logic [5:0] pin_s3_r;
  logic [2:0] sync_vld_r;
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
      pin_s3_r <= 6'h00;
      sync_vld_r <= 3'h0;
    end
    else
    begin
      pin_s1_r <= {ENC_B_REF, ENC_B_PHASE_B, ENC_B_PHASE_A,
                   ENC_A_REF, ENC_A_PHASE_B, ENC_A_PHASE_A};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      sync_vld_r <= {sync_vld_r[1:0], 1'b1};
    end
  end

  // Registers
  logic [31:0] preload_r [2];
  logic [31:0] wrap_r [2];
  logic [31:0] win_low_r;
  logic [31:0] win_high_r;
  logic [31:0] step_r;
  logic [dept_pkg::CFG_WIDTH-1:0] cfg_r;
  logic [31:0] preload_nxt [2];
  logic [31:0] wrap_nxt [2];
  logic [31:0] win_low_nxt;
  logic [31:0] win_high_nxt;
  logic [31:0] step_nxt;
  logic [dept_pkg::CFG_WIDTH-1:0] cfg_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_r;
  logic        pslverr_nxt;
  logic [3:0]  cmd_nxt;
  logic [1:0]  preload_wr_nxt;
  logic [31:0] count_r [2];
  logic [1:0]  armed_r;

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = PSEL && PENABLE && PWRITE && !pready_r;
  assign rd_acc = PSEL && PENABLE && !PWRITE && !pready_r;

  dept_pkg::dept_depth_t  depth [2];
  dept_pkg::dept_policy_t policy [2];
  dept_pkg::dept_origin_t origin;
  assign depth[0]  = dept_pkg::dept_depth_t'(
    cfg_r[dept_pkg::CFG_DEPTH_A_LSB +: 2]);
  assign depth[1]  = dept_pkg::dept_depth_t'(
    cfg_r[dept_pkg::CFG_DEPTH_B_LSB +: 2]);
  assign policy[0] = dept_pkg::dept_policy_t'(
    cfg_r[dept_pkg::CFG_POLICY_A_LSB +: 2]);
  assign policy[1] = dept_pkg::dept_policy_t'(
    cfg_r[dept_pkg::CFG_POLICY_B_LSB +: 2]);
  assign origin = dept_pkg::dept_origin_t'(
    cfg_r[dept_pkg::CFG_ORIGIN_LSB +: 3]);

  always_comb
  begin
    preload_nxt    = preload_r;
    wrap_nxt       = wrap_r;
    win_low_nxt    = win_low_r;
    win_high_nxt   = win_high_r;
    step_nxt       = step_r;
    cfg_nxt        = cfg_r;
    cmd_nxt        = 4'h0;
    preload_wr_nxt = 2'h0;
    prdata_nxt     = 32'h0000_0000;
    pslverr_nxt    = 1'b0;
    if (wr_acc)
    begin
      unique case (PADDR)
        dept_pkg::APB_PRELOAD_A:
        begin
          preload_nxt[0]    = PWDATA;
          preload_wr_nxt[0] = 1'b1;
        end
        dept_pkg::APB_PRELOAD_B:
        begin
          preload_nxt[1]    = PWDATA;
          preload_wr_nxt[1] = 1'b1;
        end
        dept_pkg::APB_WRAP_A:   wrap_nxt[0]  = PWDATA;
        dept_pkg::APB_WRAP_B:   wrap_nxt[1]  = PWDATA;
        dept_pkg::APB_WIN_LOW:  win_low_nxt  = PWDATA;
        dept_pkg::APB_WIN_HIGH: win_high_nxt = PWDATA;
        dept_pkg::APB_STEP:     step_nxt     = PWDATA;
        dept_pkg::APB_CONFIG:
          cfg_nxt = PWDATA[dept_pkg::CFG_WIDTH-1:0];
        dept_pkg::APB_COMMAND:  cmd_nxt = PWDATA[3:0];
        default:                pslverr_nxt = 1'b1;
      endcase
    end
    else if (rd_acc)
    begin
      unique case (PADDR)
        dept_pkg::APB_PRELOAD_A: prdata_nxt = preload_r[0];
        dept_pkg::APB_PRELOAD_B: prdata_nxt = preload_r[1];
        dept_pkg::APB_WRAP_A:    prdata_nxt = wrap_r[0];
        dept_pkg::APB_WRAP_B:    prdata_nxt = wrap_r[1];
        dept_pkg::APB_WIN_LOW:   prdata_nxt = win_low_r;
        dept_pkg::APB_WIN_HIGH:  prdata_nxt = win_high_r;
        dept_pkg::APB_STEP:      prdata_nxt = step_r;
        dept_pkg::APB_CONFIG:
          prdata_nxt = {21'h000000, cfg_r};
        dept_pkg::APB_COMMAND:   prdata_nxt = 32'h0000_0000;
        dept_pkg::APB_COUNT_A:   prdata_nxt = count_r[0];
        dept_pkg::APB_COUNT_B:   prdata_nxt = count_r[1];
        dept_pkg::APB_STATUS:
          prdata_nxt = {29'h00000000, MEAS_TRIG, armed_r};
        default:                 pslverr_nxt = 1'b1;
      endcase
    end
  end

  // One wait state: answer in the cycle after the first access cycle
  logic [3:0] cmd_r;
  logic [1:0] preload_wr_r;
  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      preload_r    <= '{32'h0000_0000, 32'h0000_0000};
      wrap_r       <= '{dept_pkg::RST_WRAP, dept_pkg::RST_WRAP};
      win_low_r    <= 32'h0000_0000;
      win_high_r   <= dept_pkg::RST_WIN_HIGH;
      step_r       <= 32'h0000_0000;
      cfg_r        <= dept_pkg::RST_CFG;
      cmd_r        <= 4'h0;
      preload_wr_r <= 2'h0;
      PRDATA       <= 32'h0000_0000;
      pready_r     <= 1'b0;
      PSLVERR      <= 1'b0;
    end
    else
    begin
      preload_r    <= preload_nxt;
      wrap_r       <= wrap_nxt;
      win_low_r    <= win_low_nxt;
      win_high_r   <= win_high_nxt;
      step_r       <= step_nxt;
      cfg_r        <= cfg_nxt;
      cmd_r        <= cmd_nxt;
      preload_wr_r <= preload_wr_nxt;
      PRDATA       <= prdata_nxt;
      pready_r     <= wr_acc || rd_acc;
      PSLVERR      <= pslverr_nxt;
    end
  end
  assign PREADY = pready_r;

  // Quadrature step: +1, -1 or 0 for one encoder
  function automatic logic [1:0] quad_step(
    input logic [1:0] prev,
    input logic [1:0] cur,
    input dept_pkg::dept_depth_t dep);
    logic up;
    logic dn;
    up = (prev == 2'b00 && cur == 2'b01) || (prev == 2'b01 && cur == 2'b11)
      || (prev == 2'b11 && cur == 2'b10) || (prev == 2'b10 && cur == 2'b00);
    dn = (prev == 2'b00 && cur == 2'b10) || (prev == 2'b10 && cur == 2'b11)
      || (prev == 2'b11 && cur == 2'b01) || (prev == 2'b01 && cur == 2'b00);
    // X1 counts only transitions leaving 00, X2 those on phase A edges
    unique case (dep)
      dept_pkg::DEPTH_X1:
      begin
        up = up && prev == 2'b00;
        dn = dn && prev == 2'b00;
      end
      dept_pkg::DEPTH_X2:
      begin
        up = up && (prev[0] != cur[0]);
        dn = dn && (prev[0] != cur[0]);
      end
      default:
      begin
        up = up;
        dn = dn;
      end
    endcase
    quad_step = {dn, up};
  endfunction

  // Counters
  logic [31:0] count_nxt [2];
  logic [1:0]  armed_nxt;
  logic [1:0]  mv;
  always_comb
  begin
    count_nxt = count_r;
    armed_nxt = armed_r;
    mv        = 2'h0;
    for (int i = 0; i < 2; i++)
    begin
      logic [1:0] st;
      logic       ref_rise;
      st = quad_step(pin_s3_r[3*i +: 2], pin_s2_r[3*i +: 2],
                     depth[i]);
      ref_rise = pin_s2_r[3*i+2] && !pin_s3_r[3*i+2];
      // Stage 3 holds reset zeros, not pin levels, until three edges pass
      if (!sync_vld_r[2])
      begin
        st       = 2'h0;
        ref_rise = 1'b0;
      end
      if (st[0])
      begin
        mv[i] = 1'b1;
        count_nxt[i] = (count_r[i] >= wrap_r[i]) ? 32'h0000_0000
                     : count_r[i] + 32'h0000_0001;
      end
      else if (st[1])
      begin
        mv[i] = 1'b1;
        count_nxt[i] = (count_r[i] == 32'h0000_0000) ? wrap_r[i]
                     : count_r[i] - 32'h0000_0001;
      end
      // Reference events override motion; policy none ignores marks
      if (ref_rise && policy[i] == dept_pkg::REF_EVERY)
        count_nxt[i] = preload_r[i];
      else if (ref_rise && policy[i] == dept_pkg::REF_ONCE && armed_r[i])
      begin
        count_nxt[i] = preload_r[i];
        armed_nxt[i] = 1'b0;
      end
      if (cmd_r[dept_pkg::CMD_LOAD_A + i]
          && policy[i] == dept_pkg::REF_NONE)
        count_nxt[i] = preload_r[i];
      // Re-arm after the disarm so a same-cycle request is kept
      if ((cmd_r[dept_pkg::CMD_REARM_A + i]
           && policy[i] == dept_pkg::REF_ONCE)
          || preload_wr_r[i])
        armed_nxt[i] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      count_r <= '{32'h0000_0000, 32'h0000_0000};
      armed_r <= 2'h3;
    end
    else
    begin
      count_r <= count_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Trigger: window gate plus step counter on the selected encoder
  logic [31:0] step_cnt_r;
  logic [31:0] step_cnt_nxt;
  logic        trig_nxt;
  logic        enc_sel;
  logic        sel_idx;
  logic [31:0] pos;
  logic        in_win;
  always_comb
  begin
    enc_sel = origin == dept_pkg::ORG_ENC_A
           || origin == dept_pkg::ORG_ENC_B;
    sel_idx = origin == dept_pkg::ORG_ENC_B;
    pos     = count_r[sel_idx];
    in_win  = pos >= win_low_r && pos <= win_high_r;
    step_cnt_nxt = step_cnt_r;
    trig_nxt     = 1'b0;
    if (!enc_sel)
      step_cnt_nxt = 32'h0000_0000;
    else if (step_r == 32'h0000_0000)
      trig_nxt = in_win;
    else if (mv[sel_idx])
    begin
      // Counts every step, but fires only inside the window
      if (step_cnt_r + 32'h0000_0001 >= step_r)
      begin
        step_cnt_nxt = 32'h0000_0000;
        trig_nxt     = in_win;
      end
      else
        step_cnt_nxt = step_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      step_cnt_r <= 32'h0000_0000;
      MEAS_TRIG  <= 1'b0;
    end
    else
    begin
      step_cnt_r <= step_cnt_nxt;
      MEAS_TRIG  <= trig_nxt;
    end
  end
endmodule

/* File: test/dept_top_asserts.sv */
// Port-level checker for the dual encoder trigger block
`timescale 1ns/1ps
module dept_top_asserts (
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Encoders and trigger
  input wire logic        ENC_A_PHASE_A,
  input wire logic        ENC_A_PHASE_B,
  input wire logic        ENC_A_REF,
  input wire logic        ENC_B_PHASE_A,
  input wire logic        ENC_B_PHASE_B,
  input wire logic        ENC_B_REF,
  input wire logic        MEAS_TRIG
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  sequence s_take;
    PSEL && PENABLE && !PREADY;
  endsequence
  // Nothing but pins or the bus can move a count, a window or a trigger
  sequence s_quiet;
    !PSEL && $stable({ENC_A_PHASE_A, ENC_A_PHASE_B, ENC_A_REF,
      ENC_B_PHASE_A, ENC_B_PHASE_B, ENC_B_REF});
  endsequence
  AST_TAKE_ANSWER: assert property (s_take |=> PREADY)
    else $error("ready missing after access");
  AST_READY_CAUSE: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  // Refused: past the map, not word aligned, or a write to a read-only word
  logic refuse;
  assign refuse = PADDR > dept_pkg::APB_STATUS || PADDR[1:0] != 2'h0
                  || (PWRITE && PADDR >= dept_pkg::APB_COUNT_A);
  AST_ERR_UNMAPPED: assert property (PREADY && refuse |-> PSLVERR)
    else $error("unmapped access not refused");
  AST_MAPPED_NO_ERR: assert property (PREADY && !refuse |-> !PSLVERR)
    else $error("mapped access refused");
  AST_READ_ZERO: assert property (PREADY && !PWRITE &&
    (PSLVERR || PADDR == dept_pkg::APB_COMMAND) |-> PRDATA == 32'h0)
    else $error("refused or command read not zero");
  AST_TRIG_QUIET: assert property (
    s_quiet [*8] |-> $stable(MEAS_TRIG))
    else $error("trigger moved with idle inputs");
endmodule

bind dept_top dept_top_asserts u_dept_top_asserts (
  .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .ENC_A_PHASE_A(ENC_A_PHASE_A),
  .ENC_A_PHASE_B(ENC_A_PHASE_B), .ENC_A_REF(ENC_A_REF),
  .ENC_B_PHASE_A(ENC_B_PHASE_A), .ENC_B_PHASE_B(ENC_B_PHASE_B),
  .ENC_B_REF(ENC_B_REF), .MEAS_TRIG(MEAS_TRIG));

/* File: test/dept_enc_model.sv */
// Behavioural incremental encoder with a reference track
`timescale 1ns/1ps
module dept_enc_model (
  // Clock used only to pace transitions
  input  wire logic clk,
  // Encoder pins
  output logic      pha,
  output logic      phb,
  output logic      ref_mark
);
  int pos = 0;
  initial
  begin
    pha = 1'b0;
    phb = 1'b0;
    ref_mark = 1'b0;
  end
  // Phase A leads B going up; spacing keeps every level past the sync stages
  task automatic step(input int n);
    for (int k = 0; k < (n < 0 ? -n : n); k++)
    begin
      pos = n > 0 ? pos + 1 : pos - 1;
      @(posedge clk);
      pha <= pos[1] ^ pos[0];
      phb <= pos[1];
      repeat (3) @(posedge clk);
    end
  endtask
  task automatic ref_pulse();
    @(posedge clk);
    ref_mark <= 1'b1;
    repeat (3) @(posedge clk);
    ref_mark <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* File: test/tb.sv */
// Self-checking bench for the dual encoder trigger block
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } dept_row_t;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [31:0] ca;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic        meas_trig;
  logic        a_pa, a_pb, a_ref, b_pa, b_pb, b_ref;
  int          errors = 0;
  int          n_compared = 0;
  int          trig_n = 0;
  int          t0, e, d;
  dept_row_t   rows [9];

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
    if (meas_trig === 1'b1)
      trig_n <= trig_n + 1;

  dept_top u_dept_top (
    .CORE_CLK(core_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .ENC_A_PHASE_A(a_pa),
    .ENC_A_PHASE_B(a_pb), .ENC_A_REF(a_ref), .ENC_B_PHASE_A(b_pa),
    .ENC_B_PHASE_B(b_pb), .ENC_B_REF(b_ref), .MEAS_TRIG(meas_trig));
  dept_enc_model u_enc_a (.clk(core_clk), .pha(a_pa), .phb(a_pb),
    .ref_mark(a_ref));
  dept_enc_model u_enc_b (.clk(core_clk), .pha(b_pa), .phb(b_pb),
    .ref_mark(b_ref));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] v);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      errors++;
      give_verdict();
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  // Extra wait lets the registered trigger follow the last count step
  task automatic mv(input int n);
    if (e == 1)
      u_enc_b.step(n);
    else
      u_enc_a.step(n);
    repeat (3) @(posedge core_clk);
  endtask

  initial
  begin
    rows = '{
      '{1'b0, dept_pkg::APB_PRELOAD_B, '0, '0, 1'b0},
      '{1'b0, dept_pkg::APB_WRAP_A, '0, ONES, 1'b0},
      '{1'b0, dept_pkg::APB_WRAP_B, '0, ONES, 1'b0},
      '{1'b0, dept_pkg::APB_WIN_HIGH, '0, ONES, 1'b0},
      '{1'b0, dept_pkg::APB_STATUS, '0, 32'h3, 1'b0},
      '{1'b0, 32'h30, '0, '0, 1'b1},
      '{1'b1, dept_pkg::APB_WIN_LOW, 32'h7, '0, 1'b0},
      '{1'b0, dept_pkg::APB_WIN_LOW, '0, 32'h7, 1'b0},
      '{1'b0, dept_pkg::APB_COMMAND, '0, '0, 1'b0}};
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(q, rows[i].x);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    for (e = 0; e < 2; e++)
      for (d = 0; d < 3; d++)
      begin
        ca = dept_pkg::APB_COUNT_A + 32'(4 * e);
        wr(dept_pkg::APB_CONFIG, 32'(d) << (2 * e));
        wr(dept_pkg::APB_PRELOAD_A + 32'(4 * e), 32'h10);
        wr(dept_pkg::APB_COMMAND, 32'h1 << e);
        mv(4);
        rdc(ca, 32'h10 + (32'h1 << d));
        mv(-4);
        rdc(ca, 32'h10);
      end
    e = 0;
    wr(dept_pkg::APB_CONFIG, 32'h2);
    wr(dept_pkg::APB_WRAP_A, 32'h2);
    wr(dept_pkg::APB_PRELOAD_A, 32'h1);
    wr(dept_pkg::APB_COMMAND, 32'h1);
    mv(2);
    rdc(dept_pkg::APB_COUNT_A, 32'h0);
    mv(-1);
    rdc(dept_pkg::APB_COUNT_A, 32'h2);
    wr(dept_pkg::APB_WRAP_A, ONES);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h2);
    wr(dept_pkg::APB_CONFIG, 32'h12);
    wr(dept_pkg::APB_COMMAND, 32'h1);
    rdc(dept_pkg::APB_COUNT_A, 32'h2);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h1);
    mv(1);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h2);
    wr(dept_pkg::APB_PRELOAD_A, 32'h5);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h5);
    mv(1);
    wr(dept_pkg::APB_COMMAND, 32'h4);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h5);
    wr(dept_pkg::APB_CONFIG, 32'h22);
    mv(3);
    u_enc_a.ref_pulse();
    rdc(dept_pkg::APB_COUNT_A, 32'h5);
    wr(dept_pkg::APB_CONFIG, 32'h2);
    wr(dept_pkg::APB_COMMAND, 32'h1);
    wr(dept_pkg::APB_WIN_LOW, 32'h3);
    wr(dept_pkg::APB_WIN_HIGH, 32'h4);
    mv(-2);
    chk({31'h0, meas_trig}, 32'h0);
    wr(dept_pkg::APB_CONFIG, 32'h402);
    repeat (3) @(posedge core_clk);
    chk({31'h0, meas_trig}, 32'h1);
    mv(1);
    chk({31'h0, meas_trig}, 32'h1);
    mv(1);
    chk({31'h0, meas_trig}, 32'h0);
    mv(-3);
    chk({31'h0, meas_trig}, 32'h0);
    wr(dept_pkg::APB_STEP, 32'h2);
    wr(dept_pkg::APB_WIN_LOW, 32'h0);
    wr(dept_pkg::APB_WIN_HIGH, 32'h40);
    t0 = trig_n;
    mv(4);
    chk(32'(trig_n - t0), 32'h2);
    wr(dept_pkg::APB_CONFIG, 32'h502);
    t0 = trig_n;
    mv(4);
    chk(32'(trig_n - t0), 32'h0);
    // Mid-run reset with encoder a parked off 00: no false step may follow
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk({29'h0, pready, pslverr, meas_trig}, 32'h0);
    rst <= 1'b0;
    rdc(dept_pkg::APB_STATUS, 32'h3);
    rdc(dept_pkg::APB_COUNT_A, 32'h0);
    give_verdict();
  end
endmodule
